// file: logic/dio_pkg.sv
// Package: constants and carriers for the filtered digital port
package dio_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int unsigned CH_COUNT      = 32;
    localparam int unsigned FILT_SEL_W    = 5;
    localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
    localparam int unsigned BASE_FREQ_HZ  = 8_000_000;
    // Fractional divider: add 8 per cycle, wrap at 100 -> 8 MHz average tick rate
    localparam int unsigned TICK_INC      = BASE_FREQ_HZ / 1_000_000;
    localparam int unsigned TICK_MOD      = CLK_FREQ_HZ / 1_000_000;
    localparam int unsigned TICK_ACC_W    = 7;
    localparam int unsigned FILT_CNT_W    = 32;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CH_COUNT-1:0] OUT_RESET = 32'h0000_0000;
    localparam logic [CH_COUNT-1:0] IN_RESET  = 32'h0000_0000;

    typedef logic [CH_COUNT-1:0] word_t;

    typedef struct packed {
        word_t                 irq_enable;
        word_t                 rise_select;
        logic [FILT_SEL_W-1:0] filter_n;
    } irq_cfg_s;

    typedef struct packed {
        logic  wr;
        word_t data;
    } out_wr_s;
endpackage

// file: logic/dio_filter_bit.sv
// Module: one input channel synchroniser and filter
`timescale 1ns/1ps
module dio_filter_bit
(
    input  wire logic                           clk,
    input  wire logic                           srst,
    input  wire logic                           pin_n,
    input  wire logic                           tick,
    input  wire logic [dio_pkg::FILT_CNT_W-1:0] hold_ticks,
    output logic                                level,
    output logic                                change
);
    import dio_pkg::*;

    typedef struct packed {
        logic [2:0]            sync;
        logic                  level;
        logic                  change;
        logic [FILT_CNT_W-1:0] cnt;
    } st_s;

    st_s st_reg;
    st_s st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], ~pin_n};
        st_next.change = 1'b0;
        // Only agreed stages 2 and 3 are looked at; stage 1 may be metastable
        if (st_reg.sync[2] != st_reg.sync[1] || st_reg.sync[2] == st_reg.level)
        begin
            st_next.cnt = '0;
        end
        else if (st_reg.cnt >= hold_ticks)
        begin
            st_next.level = st_reg.sync[2];
            st_next.change = 1'b1;
            st_next.cnt = '0;
        end
        else if (tick)
        begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level  = st_reg.level;
    assign change = st_reg.change;
endmodule

// file: logic/dio_port.sv
// Module: 32 in / 32 out filtered digital port with edge interrupts
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module dio_port
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire dio_pkg::word_t    in_pin_n,
    input  wire dio_pkg::out_wr_s  out_wr,
    input  wire dio_pkg::irq_cfg_s irq_cfg,
    input  wire dio_pkg::word_t    irq_clear,
    output dio_pkg::word_t         in_data,
    output dio_pkg::word_t         out_sink_on,
    output dio_pkg::word_t         irq_status,
    output logic                   irq_req
);
    import dio_pkg::*;

    typedef struct packed {
        word_t                 outs;
        word_t                 status;
        logic                  irq;
        logic [TICK_ACC_W-1:0] acc;
        logic                  tick;
        logic [FILT_CNT_W-1:0] hold;
    } st_s;

    st_s   st_reg;
    st_s   st_next;
    word_t filt_level;
    word_t filt_change;

    // ------------------------------------------------------------
    // Per channel filters
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CH_COUNT; g++)
        begin : ch
            dio_filter_bit u_filt
            (
                .clk        (clk),
                .srst       (srst),
                .pin_n      (in_pin_n[g]),
                .tick       (st_reg.tick),
                .hold_ticks (st_reg.hold),
                .level      (filt_level[g]),
                .change     (filt_change[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        word_t fire;
        fire = '0;
        st_next = st_reg;
        // Fractional divider keeps average 8 MHz without a second clock
        if (st_reg.acc + TICK_ACC_W'(TICK_INC) >= TICK_ACC_W'(TICK_MOD))
        begin
            st_next.acc = st_reg.acc + TICK_ACC_W'(TICK_INC) - TICK_ACC_W'(TICK_MOD);
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.acc = st_reg.acc + TICK_ACC_W'(TICK_INC);
            st_next.tick = 1'b0;
        end
        // Jitter of one 100 MHz cycle is the cost of the fractional tick
        st_next.hold = FILT_CNT_W'(1) << irq_cfg.filter_n;
        if (out_wr.wr)
        begin
            st_next.outs = out_wr.data;
        end
        // Rise on logical data means line went high-to-low
        fire = filt_change & irq_cfg.irq_enable
             & ~(filt_level ^ irq_cfg.rise_select);
        // Set wins over a clear in the same cycle
        st_next.status = (st_reg.status & ~irq_clear) | fire;
        st_next.irq = |(st_next.status & irq_cfg.irq_enable);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.outs <= OUT_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Plain level request; bus glue routes it, no strap needed
    assign irq_req     = st_reg.irq;
    assign out_sink_on = st_reg.outs;
    assign irq_status  = st_reg.status;
    assign in_data     = filt_level;
endmodule

// file: tb/dio_port_checker.sv
// Checker: port relations of the digital port
`timescale 1ns/1ps
module dio_port_checker import dio_pkg::*;
(
    input logic     clk, srst, irq_req,
    input out_wr_s  out_wr,
    input irq_cfg_s irq_cfg,
    input word_t    in_pin_n, irq_clear, in_data, out_sink_on, irq_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_wr; out_wr.wr |=> out_sink_on == $past(out_wr.data); endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_kp; !out_wr.wr |=> $stable(out_sink_on); endproperty
    a_kp: assert property (p_kp) else $error("hold");
    property p_rs; $fell(srst) |-> !irq_req && out_sink_on == '0; endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_rq; !$past(srst) |-> irq_req == |(irq_status & $past(irq_cfg.irq_enable)); endproperty
    a_rq: assert property (p_rq) else $error("req");
    property p_st; 1 |=> ($past(irq_status & ~irq_clear) & ~irq_status) == '0; endproperty
    a_st: assert property (p_st) else $error("sticky");
    property p_ri; (in_data & ~$past(in_data) & $past(in_pin_n, 5)) == '0; endproperty
    a_ri: assert property (p_ri) else $error("set");
    property p_fa; !$past(srst) |-> (~in_data & $past(in_data) & ~$past(in_pin_n, 5)) == '0; endproperty
    a_fa: assert property (p_fa) else $error("clear");
    // Status is set one edge after the filtered data moves
    property p_ev; (irq_status & ~$past(irq_status) & ~($past(in_data) ^ $past(in_data, 2))) == '0; endproperty
    a_ev: assert property (p_ev) else $error("event");
    c_wr: cover property (out_wr.wr);
    c_rq: cover property ($rose(irq_req));
    c_in: cover property ($rose(in_data[0]));
endmodule
bind dio_port dio_port_checker chk (.*);

// file: tb/switch_model.sv
// Model: switches on pulled-up input lines
`timescale 1ns/1ps
module switch_model import dio_pkg::*;
(
    input  word_t closed,
    output word_t pin_n
);
    assign pin_n = ~closed; // Open switch leaves pull-up high
endmodule

// file: tb/tb.sv
// Bench: filtered digital port scenarios
`timescale 1ns/1ps
module tb;
    import dio_pkg::*;
    logic     clk = 0, srst = 1, irq_req;
    word_t    sw = '0, in_pin_n, irq_clear = '0, in_data, out_sink_on, irq_status;
    out_wr_s  out_wr = '0;
    irq_cfg_s irq_cfg = '0;
    int       bad_count = 0, n_compared = 0, k;
    always #5 clk = ~clk;
    switch_model m (.closed(sw), .pin_n(in_pin_n));
    dio_port dut (.*);
    task cy(int n);
        repeat (n) @(posedge clk);
    endtask
    task cmp(word_t g, e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %0t %h", $time, g);
        end
    endtask
    // Bounded wait, k keeps cycles for timing
    task wt(word_t e);
        // Look just after the edge so the new data has settled
        for (k = 0; k < 500 && in_data !== e; k++)
        begin
            cy(1);
            #1;
        end
    endtask
    task t_clr;
        cy(1);
        irq_clear <= '1;
        cy(1);
        irq_clear <= '0;
        #1 cmp(irq_status, '0);
        cmp(irq_req, 0);
        cy(1);
        sw <= '0;
        wt(32'h0000_0000);
        cmp(k > 180 && k < 225, 1);
        cy(2);
        #1 cmp(irq_status, 32'h0000_0004);
        cmp(irq_req, 1);
    endtask
    task t_out;
        out_wr <= '{1'b1, 32'hA5A5_0F0F};
        cy(1);
        out_wr <= '{1'b1, 32'h8000_0001};
        #1 cmp(out_sink_on, 32'hA5A5_0F0F);
        cy(1);
        out_wr.wr <= 0;
        #1 cmp(out_sink_on, 32'h8000_0001);
    endtask
    task t_irq;
        cy(1);
        irq_cfg <= '{32'h0000_0005, 32'h0000_0009, 5'h04};
        sw <= '1;
        cy(60);
        sw <= '0;
        cy(300);
        cmp(in_data, '0);
        sw <= 32'h0000_000D;
        wt(32'h0000_000D);
        cmp(k > 180 && k < 225, 1);
        cy(2);
        #1 cmp(irq_status, 32'h0000_0001);
        cmp(irq_req, 1);
    endtask
    task final_report;
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        cy(12);
        srst <= 0;
        cmp(out_sink_on, '0);
        t_out;
        t_irq;
        t_clr;
        final_report;
    end
    initial
    begin
        cy(3000);
        bad_count++;
        final_report;
    end
endmodule
